// file: sds_persist.sv
/*
  sds_persist: persistence counter qualifying one fault indication.
  assumes: the indication is synchronous to clk_i.
*/
`timescale 1ns/10ps
module sds_persist #(
  parameter int unsigned COUNT = 8
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // indication
  input  wire logic raw_i,
  output logic      qual_o
);

  localparam int unsigned W = $clog2(COUNT + 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         qual;
  } sds_pers_type;

  sds_pers_type s_q;
  sds_pers_type s_d;

  always_comb begin
    s_d = s_q;
    // restarts whenever the indication drops
    if (!raw_i) begin
      s_d.cnt  = '0;
      s_d.qual = 1'b0;
    end else if (s_q.cnt == W'(COUNT - 1)) begin
      s_d.qual = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign qual_o = s_q.qual;

endmodule

// file: sds_pkg.sv
/*
  sds_pkg: constants, register map, states and carrier types of the sensor
  diagnostic supervisor.
  assumes: a single 200 MHz clock and a classic wishbone register bus.
*/
package sds_pkg;

  // clock
  localparam int unsigned CLK_MHZ = 200;

  // times, in their own units
  localparam int unsigned HIGH_HOLD_US   = 100;
  localparam int unsigned SUPPLY_QUAL_US = 40;
  localparam int unsigned FIELD_QUAL_US  = 2500;
  localparam int unsigned BOND_QUAL_US   = 200;
  localparam int unsigned DIP_LONG_US    = 80;
  localparam int unsigned DIP_SHORT_US   = 5;
  localparam int unsigned RESTART_US     = 400;

  // the same times as clock cycles
  localparam int unsigned HIGH_HOLD_CYC   = HIGH_HOLD_US * CLK_MHZ;
  localparam int unsigned SUPPLY_QUAL_CYC = SUPPLY_QUAL_US * CLK_MHZ;
  localparam int unsigned FIELD_QUAL_CYC  = FIELD_QUAL_US * CLK_MHZ;
  localparam int unsigned BOND_QUAL_CYC   = BOND_QUAL_US * CLK_MHZ;
  localparam int unsigned DIP_LONG_CYC    = DIP_LONG_US * CLK_MHZ;
  localparam int unsigned DIP_SHORT_CYC   = DIP_SHORT_US * CLK_MHZ;
  localparam int unsigned RESTART_CYC     = RESTART_US * CLK_MHZ;

  // loop counter step after a short dip
  localparam logic [7:0] LOOP_DIP_STEP = 8'h0c;

  // register byte addresses
  localparam logic [3:0] ADDR_CMD    = 4'h0;
  localparam logic [3:0] ADDR_FLAGS  = 4'h4;
  localparam logic [3:0] ADDR_LIMITS = 4'h8;
  localparam logic [3:0] ADDR_ID     = 4'hc;

  // control register fields
  localparam int unsigned CMD_ESP_EN    = 0;
  localparam int unsigned CMD_CORR_OFF  = 1;
  localparam int unsigned CMD_FIELD_EN  = 2;
  localparam int unsigned CMD_SECURE_FR = 3;
  localparam logic [3:0]  CMD_RESET     = 4'h0;

  // flags register fields
  localparam int unsigned FLG_FIELD   = 0;
  localparam int unsigned FLG_BOND    = 3;
  localparam int unsigned FLG_CORR    = 5;
  localparam int unsigned FLG_UNCORR  = 6;
  localparam int unsigned FLG_UNDER   = 7;
  localparam int unsigned FLG_RHIGH   = 8;
  localparam int unsigned FLG_RLOW    = 9;
  localparam int unsigned FLG_STATE   = 12;

  // limits register layout: lower in 15:0, upper in 31:16
  localparam int unsigned LIM_UPPER_LSB = 16;
  localparam logic [31:0] LIM_RESET     = 32'hffff_0000;

  // arbitrary neutral block identity
  localparam logic [31:0] BLOCK_ID = 32'h0000_5d5d;

  // supervisor states
  typedef enum logic [2:0] {
    ST_POR,
    ST_INIT,
    ST_HIGH,
    ST_RUN,
    ST_OVER,
    ST_UNDER
  } sds_state_type;

  // supply and memory indications from analog and memory blocks
  typedef struct packed {
    logic below_off;
    logic above_on;
    logic above_ov;
    logic below_por;
    logic dip_low;
  } sds_supply_type;

  typedef struct packed {
    logic load_done;
    logic corrected;
    logic uncorrectable;
  } sds_mem_type;

  // controls towards the framer
  typedef struct packed {
    logic       drive_low;
    logic       drive_high;
    logic       frame_run;
    logic       frame_abort;
    logic       esp_restart;
    logic       esp_diag;
    logic       prewarn;
    logic       diag_bit;
    logic [7:0] loop_add;
  } sds_frame_type;

endpackage

// file: sds_props.sv
/*
  sds_props: concurrent checks on the supervisor's pins.
  assumes: bound to sds_top, one clock, async active-low reset.
*/
`timescale 1ns/10ps
module sds_props #(
  parameter int unsigned ANGLE_W     = 16,
  parameter int unsigned SUPPLY_CYC  = 8,
  parameter int unsigned HOLD_CYC    = 10,
  parameter int unsigned RESTART_CYC = 20
) (
  // clock and reset
  input wire logic                    mclk_i,
  input wire logic                    rst_n_i,
  // bus
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [3:0]              wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  // indications and outputs
  input wire sds_pkg::sds_supply_type supply_i,
  input wire sds_pkg::sds_mem_type    mem_i,
  input wire logic                    field_weak_i,
  input wire logic                    bond_open_i,
  input wire logic [ANGLE_W-1:0]      angle_i,
  input wire logic                    frame_end_i,
  input wire logic                    out_o,
  input wire logic                    out_oe_o,
  input wire sds_pkg::sds_frame_type  frame_o
);
  localparam int RST_WIN = RESTART_CYC + 4;
  logic [15:0] flt_q;
  logic [15:0] hold_q;
  ////////////////////////////////////////////////////////////////////////////
  // run lengths of supply faults and of the high hold
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flt_q  <= 16'h0000;
      hold_q <= 16'h0000;
    end else begin
      flt_q  <= (supply_i.below_off | supply_i.above_ov) ? flt_q + 16'h0001 : 16'h0000;
      hold_q <= frame_o.drive_high ? hold_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_prewarn_run;
    frame_o.drive_low [*2] |-> !frame_o.prewarn;
  endproperty
  a_prewarn_run: assert property (p_prewarn_run) else $error("prewarn while forced low");
  // margin of three: qualify, state, pin register
  property p_supply_low;
    flt_q > SUPPLY_CYC + 3 && !supply_i.below_por |-> !out_o && frame_o.drive_low;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("supply fault not low");
  property p_release;
    $rose(rst_n_i) |-> !out_o && out_oe_o && frame_o.drive_low;
  endproperty
  a_release: assert property (p_release) else $error("pin not low at reset");
  property p_hold;
    $rose(frame_o.frame_run) && $past(frame_o.drive_high) |-> hold_q >= HOLD_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("high hold too short");
  property p_abort;
    $rose(supply_i.dip_low) && frame_o.frame_run |-> ##[1:2] frame_o.frame_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("dip without abort");
  property p_loop;
    frame_o.loop_add != 8'h00 |-> frame_o.loop_add == sds_pkg::LOOP_DIP_STEP && frame_o.frame_abort;
  endproperty
  a_loop: assert property (p_loop) else $error("bad loop step");
  property p_restart;
    $fell(supply_i.dip_low) && supply_i.above_on && !frame_o.drive_low && !frame_o.drive_high
      |-> ##[0:RST_WIN] frame_o.frame_run;
  endproperty
  a_restart: assert property (p_restart) else $error("no frame after dip");
  property p_oe;
    !out_oe_o |-> $past(supply_i.below_por);
  endproperty
  a_oe: assert property (p_oe) else $error("pin released above reset level");
  property p_force;
    frame_o.drive_low |-> !frame_o.frame_run && !out_o;
  endproperty
  a_force: assert property (p_force) else $error("frame during forced low");
endmodule

// file: sds_rx_model.sv
/*
  sds_rx_model: receiver side of the single-wire output.
  assumes: pull-up on the wire; frame boundaries every FR cycles.
*/
`timescale 1ns/10ps
module sds_rx_model #(
  parameter int unsigned FR = 12
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  input  wire logic out_i,
  input  wire logic oe_i,
  output logic      frame_end_o,
  output logic      line_o
);
  logic [7:0] cnt_q;
  ////////////////////////////////////////////////////////////////////////////
  // released pin floats to the pull-up, never the last value
  assign line_o = oe_i ? out_i : 1'b1;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q       <= 8'h00;
      frame_end_o <= 1'b0;
    end else begin
      cnt_q       <= (!run_i || cnt_q == 8'(FR - 1)) ? 8'h00 : cnt_q + 8'h01;
      frame_end_o <= run_i && cnt_q == 8'(FR - 1);
    end
  end
endmodule

// file: sds_top.sv
/*
  sds_top: diagnostic supervisor of a single-wire angle sensor output.
  assumes: indications are synchronous to mclk_i, a framer acts on frame_o,
  and software reaches the registers over classic wishbone.
*/
// What this block does
// - status bit one carries prewarning, only while running normally
// - prewarning set while range high or range low flag is set
// - corrected memory error also prewarns unless disabled by control bit
// - output held low for undervoltage or overvoltage
// - output driven low during power-on reset
// - output kept low while memory loads into shadow registers
// - output high at least 100 us before first frame
// - overvoltage state keeps core running and drives output low
// - fault classes force low, send diagnostic code, or set diagnostic bit
// - entry qualified 40 us supply, 2.5 ms field/range, 0.2 ms bond
// - corrected, uncorrectable, field and bond flags stick until reset
// - diagnostic code messages only when enhanced protocol enabled
// - supply low beyond 80 us restarts start-up with diagnostic low
// - supply dip shorter than 5 us aborts the current frame
// - new frame within 400 us after supply returns above switch-on
// - secure frame format adds 12 to loop counter after short dip
// - enhanced message sequence restarts after a short dip
// - diagnostic low below switch-off, high impedance below reset level
// - range high above upper limit, range low below lower limit
// - range flags clear once angle is back inside range
`timescale 1ns/10ps
module sds_top #(
  parameter int unsigned ANGLE_W     = 16,
  parameter int unsigned SUPPLY_CYC  = sds_pkg::SUPPLY_QUAL_CYC,
  parameter int unsigned FIELD_CYC   = sds_pkg::FIELD_QUAL_CYC,
  parameter int unsigned BOND_CYC    = sds_pkg::BOND_QUAL_CYC,
  parameter int unsigned HOLD_CYC    = sds_pkg::HIGH_HOLD_CYC,
  parameter int unsigned LONG_CYC    = sds_pkg::DIP_LONG_CYC,
  parameter int unsigned RESTART_CYC = sds_pkg::RESTART_CYC
) (
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  // wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [3:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // indications
  input  wire sds_pkg::sds_supply_type supply_i,
  input  wire sds_pkg::sds_mem_type    mem_i,
  input  wire logic                   field_weak_i,
  input  wire logic                   bond_open_i,
  input  wire logic [ANGLE_W-1:0]     angle_i,
  input  wire logic                   frame_end_i,
  // output pin and framer controls
  output logic                        out_o,
  output logic                        out_oe_o,
  output sds_pkg::sds_frame_type       frame_o
);

  localparam int unsigned TW = 32;

  typedef struct packed {
    sds_pkg::sds_state_type st;
    logic [TW-1:0]          tmr;
    logic [3:0]             cmd;
    logic [31:0]            lim;
    logic                   field_weak;
    logic                   bond_open;
    logic                   corrected;
    logic                   uncorr;
    logic                   under;
    logic                   rhigh;
    logic                   rlow;
    logic                   dip_seen;
    logic                   restart_wait;
    logic [TW-1:0]          rtmr;
    logic [31:0]            rdat;
    logic                   ack;
    logic                   out;
    logic                   oe;
    sds_pkg::sds_frame_type fr;
  } sds_top_type;

  sds_top_type s_q;
  sds_top_type s_d;

  logic               under_q;
  logic               over_q;
  logic               field_q;
  logic               bond_q;
  logic               above_q;
  logic               below_q;
  logic [ANGLE_W-1:0] upper_lim;
  logic [ANGLE_W-1:0] lower_lim;
  logic               wb_req;
  logic               low_fault;
  logic               short_dip;

  ////////////////////////////////////////////////////////////////////////////
  // qualification counters

  assign upper_lim = s_q.lim[sds_pkg::LIM_UPPER_LSB +: ANGLE_W];
  assign lower_lim = s_q.lim[ANGLE_W-1:0];

  sds_persist #(.COUNT(SUPPLY_CYC)) u_under (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (supply_i.below_off),
    .qual_o  (under_q)
  );

  sds_persist #(.COUNT(SUPPLY_CYC)) u_over (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (supply_i.above_ov),
    .qual_o  (over_q)
  );

  // field loss only counts when detection is enabled
  sds_persist #(.COUNT(FIELD_CYC)) u_field (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (field_weak_i & s_q.cmd[sds_pkg::CMD_FIELD_EN]),
    .qual_o  (field_q)
  );

  sds_persist #(.COUNT(BOND_CYC)) u_bond (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (bond_open_i),
    .qual_o  (bond_q)
  );

  sds_persist #(.COUNT(FIELD_CYC)) u_rhigh (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (angle_i > upper_lim),
    .qual_o  (above_q)
  );

  sds_persist #(.COUNT(FIELD_CYC)) u_rlow (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (angle_i < lower_lim),
    .qual_o  (below_q)
  );

  assign wb_req    = wb_cyc_i & wb_stb_i & ~s_q.ack;
  // faults that force the pin low
  assign low_fault = under_q | over_q | s_q.uncorr;
  assign short_dip = supply_i.dip_low;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.fr.frame_abort = 1'b0;
    s_d.fr.esp_restart = 1'b0;
    s_d.fr.loop_add = 8'h00;

    if (mem_i.corrected) begin
      s_d.corrected = 1'b1;
    end
    if (mem_i.uncorrectable) begin
      s_d.uncorr = 1'b1;
    end
    if (field_q) begin
      s_d.field_weak = 1'b1;
    end
    if (bond_q) begin
      s_d.bond_open = 1'b1;
    end
    s_d.under = under_q;
    // range flags follow the qualified comparison
    s_d.rhigh = above_q;
    s_d.rlow  = below_q;

    unique case (s_q.st)
      sds_pkg::ST_POR: begin
        s_d.st = sds_pkg::ST_INIT;
        s_d.tmr = '0;
      end
      sds_pkg::ST_INIT: begin
        if (mem_i.load_done && supply_i.above_on && !low_fault) begin
          s_d.st = sds_pkg::ST_HIGH;
          s_d.tmr = '0;
        end
      end
      // hold the pin high before the first frame
      sds_pkg::ST_HIGH: begin
        if (low_fault) begin
          s_d.st = over_q ? sds_pkg::ST_OVER : sds_pkg::ST_UNDER;
          s_d.tmr = '0;
        end else if (s_q.tmr == TW'(HOLD_CYC - 1)) begin
          s_d.st = sds_pkg::ST_RUN;
        end else begin
          s_d.tmr = s_q.tmr + TW'(1);
        end
      end
      sds_pkg::ST_RUN: begin
        // low faults win over the frame
        if (low_fault) begin
          s_d.st = over_q ? sds_pkg::ST_OVER : sds_pkg::ST_UNDER;
          s_d.tmr = '0;
          s_d.fr.frame_abort = 1'b1;
        end else if (short_dip && !s_q.dip_seen) begin
          s_d.dip_seen = 1'b1;
          s_d.fr.frame_abort = 1'b1;
          s_d.restart_wait = 1'b1;
          s_d.rtmr = '0;
          if (s_q.cmd[sds_pkg::CMD_SECURE_FR]) begin
            s_d.fr.loop_add = sds_pkg::LOOP_DIP_STEP;
          end
          if (s_q.cmd[sds_pkg::CMD_ESP_EN]) begin
            s_d.fr.esp_restart = 1'b1;
          end
        end
        if (!short_dip) begin
          s_d.dip_seen = 1'b0;
        end
      end
      sds_pkg::ST_OVER: begin
        if (!over_q) begin
          s_d.st = sds_pkg::ST_HIGH;
          s_d.tmr = '0;
        end
      end
      sds_pkg::ST_UNDER: begin
        if (s_q.tmr != TW'(LONG_CYC)) begin
          s_d.tmr = s_q.tmr + TW'(1);
        end
        if (!under_q && !s_q.uncorr && supply_i.above_on) begin
          s_d.st = (s_q.tmr == TW'(LONG_CYC)) ? sds_pkg::ST_INIT : sds_pkg::ST_HIGH;
          s_d.tmr = '0;
        end
      end
      default: begin
        s_d.st = sds_pkg::ST_POR;
      end
    endcase

    // restart the frame no later than the bound after the dip
    if (s_q.restart_wait) begin
      if (!short_dip && supply_i.above_on) begin
        if (frame_end_i || s_q.rtmr == TW'(RESTART_CYC - 1)) begin
          s_d.restart_wait = 1'b0;
        end else begin
          s_d.rtmr = s_q.rtmr + TW'(1);
        end
      end
    end

    // pin stage: release below reset level, else drive
    s_d.oe  = ~supply_i.below_por;
    s_d.out = (s_d.st == sds_pkg::ST_HIGH) || (s_d.st == sds_pkg::ST_RUN);
    s_d.fr.drive_low  = ~s_d.out;
    s_d.fr.drive_high = s_d.st == sds_pkg::ST_HIGH;
    s_d.fr.frame_run  = (s_d.st == sds_pkg::ST_RUN) & ~s_d.restart_wait;

    s_d.fr.prewarn = (s_d.st == sds_pkg::ST_RUN) &
                     (s_d.rhigh | s_d.rlow |
                      (s_d.corrected & ~s_q.cmd[sds_pkg::CMD_CORR_OFF]));
    // diagnostic bit for field loss and open bridge
    s_d.fr.diag_bit = s_d.field_weak | s_d.bond_open;
    // diagnostic code message only with enhanced protocol
    s_d.fr.esp_diag = s_q.cmd[sds_pkg::CMD_ESP_EN] & (s_d.st == sds_pkg::ST_RUN) &
                      (s_d.corrected | s_d.field_weak | s_d.bond_open |
                       s_d.rhigh | s_d.rlow);

    // register bus, one wait state; a write lands at the edge that sees ack
    if (wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack) begin
      if (wb_adr_i == sds_pkg::ADDR_CMD && wb_sel_i[0]) begin
        s_d.cmd = wb_dat_i[3:0];
      end
      if (wb_adr_i == sds_pkg::ADDR_LIMITS) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            s_d.lim[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
      end
    end
    if (wb_req) begin
      s_d.ack = 1'b1;
      s_d.rdat = '0;
      if (!wb_we_i) begin
        unique case (wb_adr_i)
          sds_pkg::ADDR_CMD:    s_d.rdat = {28'h0000000, s_q.cmd};
          sds_pkg::ADDR_LIMITS: s_d.rdat = s_q.lim;
          sds_pkg::ADDR_ID:     s_d.rdat = sds_pkg::BLOCK_ID;
          sds_pkg::ADDR_FLAGS: begin
            s_d.rdat[sds_pkg::FLG_FIELD]  = s_q.field_weak;
            s_d.rdat[sds_pkg::FLG_BOND]   = s_q.bond_open;
            s_d.rdat[sds_pkg::FLG_CORR]   = s_q.corrected;
            s_d.rdat[sds_pkg::FLG_UNCORR] = s_q.uncorr;
            s_d.rdat[sds_pkg::FLG_UNDER]  = s_q.under;
            s_d.rdat[sds_pkg::FLG_RHIGH]  = s_q.rhigh;
            s_d.rdat[sds_pkg::FLG_RLOW]   = s_q.rlow;
            s_d.rdat[sds_pkg::FLG_STATE +: 3] = s_q.st;
          end
          default: s_d.rdat = '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q     <= '0;
      s_q.st  <= sds_pkg::ST_POR;
      s_q.cmd <= sds_pkg::CMD_RESET;
      s_q.lim <= sds_pkg::LIM_RESET;
      s_q.oe  <= 1'b1;
      s_q.fr.drive_low <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdat;
  assign wb_ack_o = s_q.ack;
  assign out_o    = s_q.out;
  assign out_oe_o = s_q.oe;
  assign frame_o  = s_q.fr;

endmodule

// file: tb_top.sv
/*
  tb_top: register-level and pin-level scenarios for sds_top.
  assumes: shortened qualification counts set at the instance.
*/
`timescale 1ns/10ps
module tb_top;
  logic                    mclk_i = 1'b0;
  logic                    rst_n_i = 1'b0;
  logic                    cyc = 1'b0, stb = 1'b0, we = 1'b0, fw = 1'b0, bo = 1'b0;
  logic [3:0]              adr = 4'h0, sel = 4'h0, wsel = 4'hf;
  logic [31:0]             dat = 32'h0, wdo, q;
  logic [15:0]             ang = 16'h4000;
  logic                    ack, fe, out, oe, line;
  sds_pkg::sds_supply_type sup = '0;
  sds_pkg::sds_mem_type    mem = '0;
  sds_pkg::sds_frame_type  fr;
  int                      n_errors = 0, checked = 0, cycles = 0;
  always #2.5 mclk_i = ~mclk_i;
  // long-dip count keeps its real value so the under state sees the true long-dip bound
  sds_top #(.SUPPLY_CYC(8), .FIELD_CYC(16), .BOND_CYC(8), .HOLD_CYC(10),
    .RESTART_CYC(20)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wdo),
    .wb_ack_o(ack), .supply_i(sup), .mem_i(mem), .field_weak_i(fw), .bond_open_i(bo),
    .angle_i(ang), .frame_end_i(fe), .out_o(out), .out_oe_o(oe), .frame_o(fr));
  sds_rx_model rx (.clk_i(mclk_i), .rst_n_i(rst_n_i), .run_i(fr.frame_run), .out_i(out),
    .oe_i(oe), .frame_end_o(fe), .line_o(line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // held until ack is seen, then one idle cycle; only the cycle ceiling ends a wait
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= wsel;
    do begin
      @(posedge mclk_i);
    end while (ack !== 1'b1);
    q = wdo;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic wrun(input int lim);
    repeat (lim) if (fr.frame_run !== 1'b1) @(posedge mclk_i);
    chk(fr.frame_run, 1);
  endtask
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    step(16);
    chk({out, oe, fr.drive_low}, 3'b011);
    rst_n_i <= 1'b1;
    wb(0, 4'h0, 0); chk(q, 0);
    wb(0, 4'h8, 0); chk(q, 32'hffff0000);
    wb(1, 4'hc, 1); wb(0, 4'hc, 0); chk(q, sds_pkg::BLOCK_ID);
    wb(1, 4'h2, 32'hff); wb(0, 4'h2, 0); chk(q, 0);
    step(20); chk(out, 0);
    sup.above_on <= 1'b1; mem.load_done <= 1'b1;
    step(4); chk(out, 1);
    wrun(40);
    wb(1, 4'h8, 32'h8000_1000);
    ang <= 16'h9000; step(24); chk(fr.prewarn, 1);
    wb(0, 4'h4, 0); chk(q & 32'h300, 32'h100);
    ang <= 16'h4000; step(3); chk(fr.prewarn, 0);
    ang <= 16'h0100; step(24); wb(0, 4'h4, 0); chk(q & 32'h300, 32'h200);
    ang <= 16'h4000; bo <= 1'b1; step(4); bo <= 1'b0; step(4);
    wb(0, 4'h4, 0); chk(q & 32'h8, 0);
    wb(1, 4'h0, 32'h4); fw <= 1'b1; bo <= 1'b1; step(24);
    chk({fr.diag_bit, fr.esp_diag}, 2'b10);
    fw <= 1'b0; bo <= 1'b0; wb(0, 4'h4, 0); chk(q & 32'h9, 32'h9);
    wb(1, 4'h0, 32'h5); step(2); chk(fr.esp_diag, 1);
    wb(1, 4'h0, 32'h7); mem.corrected <= 1'b1; step(1); mem.corrected <= 1'b0; step(4);
    chk(fr.prewarn, 0);
    wb(0, 4'h4, 0); chk(q & 32'h20, 32'h20);
    wb(1, 4'h0, 32'hd); step(3); chk(fr.prewarn, 1);
    sup.dip_low <= 1'b1;
    repeat (4) if (fr.frame_abort !== 1'b1) @(posedge mclk_i);
    chk({fr.frame_abort, fr.esp_restart}, 2'b11);
    chk(fr.loop_add, 8'h0c);
    sup.dip_low <= 1'b0; wrun(30);
    sup.below_off <= 1'b1; step(4); sup.below_off <= 1'b0; step(4);
    chk(fr.drive_low, 0);
    sup.below_off <= 1'b1; sup.above_on <= 1'b0; step(14);
    chk({out, fr.prewarn}, 2'b00);
    wb(0, 4'h4, 0); chk(q & 32'h80, 32'h80);
    step(int'(sds_pkg::DIP_LONG_CYC) + 10);
    sup.below_off <= 1'b0; sup.above_on <= 1'b1; mem.load_done <= 1'b0; step(1);
    chk(fr.frame_run, 0);
    step(3); wb(0, 4'h4, 0); chk(32'(q[14:12]), 32'(sds_pkg::ST_INIT));
    chk(out, 0);
    mem.load_done <= 1'b1; wrun(80);
    sup.above_ov <= 1'b1; step(14); chk({out, oe, fr.prewarn}, 3'b010);
    wb(0, 4'hc, 0); chk(q, sds_pkg::BLOCK_ID);
    sup.above_ov <= 1'b0; wrun(80);
    mem.uncorrectable <= 1'b1; step(1); mem.uncorrectable <= 1'b0; step(4);
    chk({out, fr.frame_run}, 2'b00);
    wb(0, 4'h4, 0); chk(q & 32'h40, 32'h40);
    sup.below_por <= 1'b1; step(3); chk({oe, line}, 2'b01);
    // byte lanes: limits per lane, control only through lane zero
    wsel = 4'h4; wb(1, 4'h8, 32'h1234_5678); wb(1, 4'h0, 32'h0); wsel = 4'hf;
    wb(0, 4'h8, 0); chk(q, 32'h8034_1000);
    wb(0, 4'h0, 0); chk(q, 32'hd);
    // second power-on reset clears the sticky flags
    rst_n_i <= 1'b0; sup.below_por <= 1'b0; step(2);
    chk({out, oe, fr.drive_low}, 3'b011);
    rst_n_i <= 1'b1; wb(0, 4'h4, 0); chk(q & 32'h3ff, 0);
    wb(0, 4'h8, 0); chk(q, 32'hffff0000);
    wrun(40);
    end_sim();
  end
endmodule
bind sds_top sds_props #(.ANGLE_W(ANGLE_W), .SUPPLY_CYC(SUPPLY_CYC), .HOLD_CYC(HOLD_CYC),
  .RESTART_CYC(RESTART_CYC)) u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .supply_i(supply_i), .mem_i(mem_i), .field_weak_i(field_weak_i),
  .bond_open_i(bond_open_i), .angle_i(angle_i), .frame_end_i(frame_end_i),
  .out_o(out_o), .out_oe_o(out_oe_o), .frame_o(frame_o));
